/* timer_cfg_defs.svh */
// offsets, field positions, reset values and timing counts of the timer configuration block
`ifndef TIMER_CFG_DEFS_SVH
`define TIMER_CFG_DEFS_SVH

`define TMR_ADDR_W 10
`define TMR_ADDR_AB_IO 10'h124
`define TMR_ADDR_CD_IO 10'h125
`define TMR_ADDR_MODE 10'h120
`define TMR_ADDR_CTRL_ONE 10'h121
`define TMR_ADDR_CTRL_TWO 10'h122
`define TMR_ADDR_FILTER 10'h126
`define TMR_ADDR_FAST_OSC 10'h127
`define TMR_ADDR_PORT3_DIR 10'h128
`define TMR_ADDR_STATUS 10'h12F

`define TMR_IO_RESET 8'h88
`define TMR_AB_UNUSED_MASK 8'h80
`define TMR_CD_UNUSED_MASK 8'h88
`define TMR_READ_UNMAPPED 8'h00

`define TMR_IO_LO_MODE_SEL 2
`define TMR_IO_CAP_SRC 3
`define TMR_IO_HI_MODE_SEL 6
`define TMR_MODE_BUF_C 4
`define TMR_MODE_BUF_D 5
`define TMR_FILT_TRIG_LSB 4
`define TMR_P3_BIT3 3

`define TMR_PRESC_W 5
`define TMR_CLK_PERIOD_NS 40
`define TMR_EXT_MIN_PULSE_CYC 3

`endif

/* timer_cfg_pkg.sv */
// types shared by the timer configuration block
package timer_cfg_pkg;

  typedef enum logic [1:0] {
    MODE_TIMER = 2'b00,
    MODE_PWM = 2'b01,
    MODE_PWM2 = 2'b10,
    MODE_RSVD = 2'b11
  } mode_t;

  typedef enum logic [2:0] {
    SEL_F1 = 3'b000,
    SEL_F2 = 3'b001,
    SEL_F4 = 3'b010,
    SEL_F8 = 3'b011,
    SEL_F32 = 3'b100,
    SEL_EXT = 3'b101,
    SEL_FAST = 3'b110,
    SEL_NONE = 3'b111
  } clk_sel_t;

  typedef struct packed {
    logic pulse;
    logic s3;
    logic s2;
    logic s1;
  } edge_state_t;

  typedef struct packed {
    logic [7:0] ab_io;
    logic [7:0] cd_io;
    mode_t mode;
    logic buf_c;
    logic buf_d;
    clk_sel_t clk_sel;
    logic [1:0] trig_edge;
    logic [3:0] filt_cap;
    logic [1:0] trig_cfg;
    logic fast_on;
    logic p33_dir;
    logic [4:0] presc;
    logic [7:0] rdata;
    logic cnt_en;
    logic [3:0] cap_eff;
    logic [7:0] ctrl_eff;
    logic cap_a_trig;
    logic [3:0] filt_eff;
    logic [1:0] trig_eff;
  } state_t;

endpackage : timer_cfg_pkg

/* edge_if.sv */
// level in, synchronised level and rising-edge pulse out
`timescale 1ns/1ns
interface edge_if;
  logic level;
  logic sync;
  logic pulse;
  modport det (input level, output sync, output pulse);
  modport user (output level, input sync, input pulse);
endinterface : edge_if

/* edge_sync.sv */
// two-stage synchroniser with single-cycle rising-edge pulse
`timescale 1ns/1ns
module edge_sync (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // pin side and detector outputs
  edge_if.det e
);
  import timer_cfg_pkg::*;

  edge_state_t st_q;
  edge_state_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.s1 = e.level;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    st_d.pulse = st_q.s2 & ~st_q.s3; // R19
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign e.sync = st_q.s2;
  assign e.pulse = st_q.pulse;

  AST_EDGE_ONE_CYCLE: assert property (@(posedge clk_in) disable iff (rst_in) // R19
    st_q.pulse |=> !st_q.pulse) else $error("edge pulse longer than one cycle");

endmodule : edge_sync

/* timer_channel_mode_and_clock_select.sv */
// channel mode, capture source and count source selection of the timer
//
// Contract
// R1 - channel A mode bit: 0 compare, 1 capture
// R2 - channel B mode bit: 0 compare, 1 capture
// R3 - channel C mode bit: 0 compare, 1 capture
// R4 - channel D mode bit: 0 compare, 1 capture
// R5 - A capture source: 0 slow clock, 1 pin
// R6 - A source switch only in capture mode
// R7 - io control acts only in timer mode
// R8 - software matches C mode to A when buffered
// R9 - software matches D mode to B when buffered
// R10 - unused io control bits read as one
// R11 - capture filter bits only for capture channels
// R12 - trigger bits only PWM2 with trigger enabled
// R13 - count source same in every mode
// R14 - select divide by 1,2,4,8,32
// R15 - 110b picks fast clock when oscillator on
// R16 - 101b counts external edges, input direction
// R17 - software enables oscillator before selecting 110b
// R18 - external pulses last three clocks minimum
// R19 - synchronise pin, one-cycle count enable
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ns
`include "timer_cfg_defs.svh"
module timer_channel_mode_and_clock_select (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // register port
  input wire logic [`TMR_ADDR_W-1:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  // clock and capture sources
  input wire logic ext_count_clock_pin_in,
  input wire logic channel_a_pin_in,
  input wire logic slow_onchip_divided_clock_in,
  input wire logic fast_onchip_clock_in,
  // effects on the timer core
  output logic count_en_out,
  output logic [3:0] chan_capture_out,
  output logic [7:0] chan_ctrl_out,
  output logic chan_a_capture_trig_out,
  output logic [3:0] filter_cap_en_out,
  output logic [1:0] trig_cfg_out,
  output timer_cfg_pkg::mode_t timer_mode_out,
  output logic buffer_c_for_a_out,
  output logic buffer_d_for_b_out
);
  import timer_cfg_pkg::*;

  state_t st_q;
  state_t st_d;
  logic timer_mode;
  logic [3:0] mode_bits;
  logic [7:0] ctrl_bits;

  edge_if ext_if ();
  edge_if pina_if ();
  edge_if slow_if ();

  assign ext_if.level = ext_count_clock_pin_in;
  assign pina_if.level = channel_a_pin_in;
  assign slow_if.level = slow_onchip_divided_clock_in;

  edge_sync ext_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .e(ext_if.det)
  );

  edge_sync pina_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .e(pina_if.det)
  );

  edge_sync slow_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .e(slow_if.det)
  );

  assign timer_mode = (st_q.mode == MODE_TIMER);
  assign mode_bits = {st_q.cd_io[`TMR_IO_HI_MODE_SEL], st_q.cd_io[`TMR_IO_LO_MODE_SEL],
                      st_q.ab_io[`TMR_IO_HI_MODE_SEL], st_q.ab_io[`TMR_IO_LO_MODE_SEL]};
  assign ctrl_bits = {st_q.cd_io[5:4], st_q.cd_io[1:0], st_q.ab_io[5:4], st_q.ab_io[1:0]};

  always_comb begin
    st_d = st_q;
    st_d.presc = st_q.presc + 5'h01;
    // register writes; unassigned io bits are not stored
    if (wr_in) begin
      case (addr_in)
        `TMR_ADDR_AB_IO: begin
          st_d.ab_io = wdata_in & ~`TMR_AB_UNUSED_MASK;
        end
        `TMR_ADDR_CD_IO: begin
          st_d.cd_io = wdata_in & ~`TMR_CD_UNUSED_MASK;
        end
        `TMR_ADDR_MODE: begin
          st_d.mode = mode_t'(wdata_in[1:0]);
          st_d.buf_c = wdata_in[`TMR_MODE_BUF_C];
          st_d.buf_d = wdata_in[`TMR_MODE_BUF_D];
        end
        `TMR_ADDR_CTRL_ONE: begin
          st_d.clk_sel = clk_sel_t'(wdata_in[2:0]);
        end
        `TMR_ADDR_CTRL_TWO: begin
          st_d.trig_edge = wdata_in[1:0];
        end
        `TMR_ADDR_FILTER: begin
          st_d.filt_cap = wdata_in[3:0];
          st_d.trig_cfg = wdata_in[`TMR_FILT_TRIG_LSB+1:`TMR_FILT_TRIG_LSB];
        end
        `TMR_ADDR_FAST_OSC: begin
          st_d.fast_on = wdata_in[0];
        end
        `TMR_ADDR_PORT3_DIR: begin
          st_d.p33_dir = wdata_in[`TMR_P3_BIT3];
        end
        default: begin
        end
      endcase
    end
    // read data stands in the cycle after the strobe only
    st_d.rdata = 8'h00;
    if (rd_in) begin
      case (addr_in)
        `TMR_ADDR_AB_IO: st_d.rdata = st_q.ab_io | `TMR_AB_UNUSED_MASK; // R10
        `TMR_ADDR_CD_IO: st_d.rdata = st_q.cd_io | `TMR_CD_UNUSED_MASK; // R10
        `TMR_ADDR_MODE: st_d.rdata = {2'h0, st_q.buf_d, st_q.buf_c, 2'h0, st_q.mode};
        `TMR_ADDR_CTRL_ONE: st_d.rdata = {5'h00, st_q.clk_sel};
        `TMR_ADDR_CTRL_TWO: st_d.rdata = {6'h00, st_q.trig_edge};
        `TMR_ADDR_FILTER: st_d.rdata = {2'h0, st_q.trig_cfg, st_q.filt_cap};
        `TMR_ADDR_FAST_OSC: st_d.rdata = {7'h00, st_q.fast_on};
        `TMR_ADDR_PORT3_DIR: st_d.rdata = {4'h0, st_q.p33_dir, 3'h0};
        `TMR_ADDR_STATUS: st_d.rdata = {3'h0, timer_mode, st_q.cap_eff};
        default: st_d.rdata = `TMR_READ_UNMAPPED;
      endcase
    end
    // count source, independent of the operating mode
    case (st_q.clk_sel) // R13
      SEL_F1: st_d.cnt_en = 1'b1; // R14
      SEL_F2: st_d.cnt_en = st_q.presc[0]; // R14
      SEL_F4: st_d.cnt_en = &st_q.presc[1:0]; // R14
      SEL_F8: st_d.cnt_en = &st_q.presc[2:0]; // R14
      SEL_F32: st_d.cnt_en = &st_q.presc[4:0]; // R14
      SEL_EXT: st_d.cnt_en = ext_if.pulse & ~st_q.p33_dir; // R16 R19
      SEL_FAST: st_d.cnt_en = fast_onchip_clock_in & st_q.fast_on; // R15
      default: st_d.cnt_en = 1'b0;
    endcase
    // io control only governs channels in timer mode
    st_d.cap_eff = timer_mode ? mode_bits : 4'h0; // R1 R2 R3 R4 R7
    st_d.ctrl_eff = timer_mode ? ctrl_bits : 8'h00; // R7
    st_d.cap_a_trig = 1'b0;
    if (timer_mode && st_q.ab_io[`TMR_IO_LO_MODE_SEL]) begin // R6
      st_d.cap_a_trig = st_q.ab_io[`TMR_IO_CAP_SRC] ? pina_if.sync : slow_if.sync; // R5
    end
    st_d.filt_eff = st_q.filt_cap & st_d.cap_eff; // R11
    st_d.trig_eff = ((st_q.mode == MODE_PWM2) && (st_q.trig_edge != 2'b00)) ?
                    st_q.trig_cfg : 2'b00; // R12
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_q <= '0;
      st_q.ab_io <= `TMR_IO_RESET & ~`TMR_AB_UNUSED_MASK;
      st_q.cd_io <= `TMR_IO_RESET & ~`TMR_CD_UNUSED_MASK;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata_out = st_q.rdata;
  assign count_en_out = st_q.cnt_en;
  assign chan_capture_out = st_q.cap_eff;
  assign chan_ctrl_out = st_q.ctrl_eff;
  assign chan_a_capture_trig_out = st_q.cap_a_trig;
  assign filter_cap_en_out = st_q.filt_eff;
  assign trig_cfg_out = st_q.trig_eff;
  assign timer_mode_out = st_q.mode;
  assign buffer_c_for_a_out = st_q.buf_c;
  assign buffer_d_for_b_out = st_q.buf_d;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  AST_CHAN_A_MODE: assert property ( // R1
    timer_mode |=> chan_capture_out[0] == $past(st_q.ab_io[2]))
    else $error("channel A mode not applied");
  AST_CHAN_B_MODE: assert property ( // R2
    timer_mode |=> chan_capture_out[1] == $past(st_q.ab_io[6]))
    else $error("channel B mode not applied");
  AST_CHAN_C_MODE: assert property ( // R3
    timer_mode |=> chan_capture_out[2] == $past(st_q.cd_io[2]))
    else $error("channel C mode not applied");
  AST_CHAN_D_MODE: assert property ( // R4
    timer_mode |=> chan_capture_out[3] == $past(st_q.cd_io[6]))
    else $error("channel D mode not applied");
  AST_CAP_SRC_PIN: assert property ( // R5
    (timer_mode && st_q.ab_io[2] && st_q.ab_io[3])
      |=> chan_a_capture_trig_out == $past(pina_if.sync))
    else $error("channel A capture source wrong");
  AST_CAP_SRC_IGNORED: assert property ( // R6
    !(timer_mode && st_q.ab_io[2]) |=> !chan_a_capture_trig_out)
    else $error("capture source active outside capture");
  AST_NON_TIMER_IDLE: assert property ( // R7
    !timer_mode |=> (chan_capture_out == 4'h0) && (chan_ctrl_out == 8'h00))
    else $error("io control active outside timer mode");
  AST_UNUSED_READ_ONE: assert property ( // R10
    (rd_in && addr_in == `TMR_ADDR_CD_IO) |=> rdata_out[7] && rdata_out[3])
    else $error("unassigned io bits not read as one");
  AST_FILTER_CAPTURE_ONLY: assert property ( // R11
    (filter_cap_en_out & ~chan_capture_out) == 4'h0)
    else $error("filter bit active on compare channel");
  AST_TRIG_PWM2_ONLY: assert property ( // R12
    !((st_q.mode == MODE_PWM2) && (st_q.trig_edge != 2'b00)) |=> trig_cfg_out == 2'b00)
    else $error("trigger bits active outside PWM2");
  AST_F32_RATE: assert property ( // R14
    (st_q.clk_sel == SEL_F32) && (st_q.presc != 5'h1F) |=> !count_en_out)
    else $error("divide by 32 enable at wrong time");
  AST_FAST_NEEDS_OSC: assert property ( // R15
    (st_q.clk_sel == SEL_FAST) && !st_q.fast_on |=> !count_en_out)
    else $error("fast clock counted with oscillator off");
  AST_EXT_DIR_INPUT: assert property ( // R16
    (st_q.clk_sel == SEL_EXT) && ext_if.pulse |=> count_en_out == !$past(st_q.p33_dir))
    else $error("external edge count wrong");

  // capture source, io control, register access, filter and trigger checks
  AST_CAP_SRC_SLOW: assert property ( // R5
    (timer_mode && st_q.ab_io[2] && !st_q.ab_io[3])
      |=> chan_a_capture_trig_out == $past(slow_if.sync))
    else $error("channel A slow capture source wrong");
  AST_CTRL_APPLIED: assert property ( // R7
    timer_mode
      |=> chan_ctrl_out == $past(ctrl_bits))
    else $error("channel control bits not applied in timer mode");
  AST_AB_UNUSED_READ: assert property ( // R10
    (rd_in && addr_in == `TMR_ADDR_AB_IO)
      |=> rdata_out[7])
    else $error("unassigned channel A B io bit not read as one");
  AST_AB_IO_DROP: assert property ( // R10
    (wr_in && addr_in == `TMR_ADDR_AB_IO)
      |=> (st_q.ab_io & `TMR_AB_UNUSED_MASK) == 8'h00)
    else $error("unassigned channel A B io bit stored");
  AST_CD_IO_DROP: assert property ( // R10
    (wr_in && addr_in == `TMR_ADDR_CD_IO)
      |=> (st_q.cd_io & `TMR_CD_UNUSED_MASK) == 8'h00)
    else $error("unassigned channel C D io bits stored");
  AST_STATUS_READ: assert property ( // R1 R2 R3 R4
    (rd_in && addr_in == `TMR_ADDR_STATUS)
      |=> rdata_out == {3'h0, $past(timer_mode), $past(chan_capture_out)})
    else $error("status read does not show effective capture");
  AST_FILTER_PASS: assert property ( // R11
    timer_mode
      |=> filter_cap_en_out == $past(st_q.filt_cap & mode_bits))
    else $error("filter bit lost on capture channel");
  AST_TRIG_PASS: assert property ( // R12
    ((st_q.mode == MODE_PWM2) && (st_q.trig_edge != 2'b00))
      |=> trig_cfg_out == $past(st_q.trig_cfg))
    else $error("trigger bits not applied in PWM2");

  // count source checks
  AST_F1_RATE: assert property ( // R14
    !rst_in && (st_q.clk_sel == SEL_F1)
      |=> count_en_out)
    else $error("divide by 1 enable missing");
  AST_F2_RATE: assert property ( // R14
    (st_q.clk_sel == SEL_F2)
      |=> count_en_out == $past(st_q.presc[0]))
    else $error("divide by 2 enable at wrong time");
  AST_F4_RATE: assert property ( // R14
    (st_q.clk_sel == SEL_F4)
      |=> count_en_out == $past(&st_q.presc[1:0]))
    else $error("divide by 4 enable at wrong time");
  AST_F8_RATE: assert property ( // R14
    (st_q.clk_sel == SEL_F8)
      |=> count_en_out == $past(&st_q.presc[2:0]))
    else $error("divide by 8 enable at wrong time");
  AST_F32_PULSE: assert property ( // R14
    (st_q.clk_sel == SEL_F32) && (st_q.presc == 5'h1F)
      |=> count_en_out)
    else $error("divide by 32 enable missing");
  AST_SEL_NONE_IDLE: assert property ( // R14
    (st_q.clk_sel == SEL_NONE)
      |=> !count_en_out)
    else $error("count enable on unused select");
  AST_FAST_TICK: assert property ( // R15
    (st_q.clk_sel == SEL_FAST) && st_q.fast_on
      |=> count_en_out == $past(fast_onchip_clock_in))
    else $error("fast clock tick not counted");
  AST_EXT_EDGE_ONLY: assert property ( // R19
    (st_q.clk_sel == SEL_EXT) && !ext_if.pulse
      |=> !count_en_out)
    else $error("external count without edge");

  COV_EXT_COUNT: cover property ((st_q.clk_sel == SEL_EXT) ##1 count_en_out);
  COV_CAPTURE_ALL: cover property (chan_capture_out == 4'hF);
  COV_PWM2_TRIGGER: cover property (trig_cfg_out != 2'b00);
  COV_FAST_COUNT: cover property ((st_q.clk_sel == SEL_FAST) && count_en_out);
  COV_CAP_A_PIN: cover property (chan_a_capture_trig_out && st_q.ab_io[3]);

endmodule : timer_channel_mode_and_clock_select

/* ext_clock_model.sv */
// partner model: external count clock pin driven with pulses of random length
`timescale 1ns/1ns
module ext_clock_model (
  // clock and request
  input wire logic clk_in,
  input wire logic go_in,
  // pin
  output logic pin_out
);
  int len;
  initial pin_out = 1'b0;
  // five pulses, each level held three to six clocks, then the pin rests low
  always begin
    @(posedge go_in);
    repeat (5) begin
      len = 3 + ($urandom % 4);
      repeat (len) @(posedge clk_in);
      pin_out <= 1'b1;
      len = 3 + ($urandom % 4);
      repeat (len) @(posedge clk_in);
      pin_out <= 1'b0;
    end
  end
endmodule : ext_clock_model

/* test_timer_channel_mode_and_clock_select.sv */
// self-checking testbench of the timer channel mode and clock select block
`timescale 1ns/1ns
`include "timer_cfg_defs.svh"
module test_timer_channel_mode_and_clock_select;
  import timer_cfg_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic rd_prev = 1'b0;
  logic go = 1'b0;
  logic pa = 1'b0;
  logic sl = 1'b0;
  logic fast = 1'b0;
  logic [`TMR_ADDR_W-1:0] addr_in = '0;
  logic [7:0] wdata_in = 8'h00;
  logic [7:0] rdata_out, chan_ctrl_out, ab, cd, wf, mv;
  logic ext_pin, count_en_out, trig_a, buf_c, buf_d;
  logic [3:0] cap_out, filt_out, cap;
  logic [1:0] trig_out;
  mode_t md;
  logic [7:0] expq[$];
  int err_total = 0;
  int total_checks = 0;
  int cycles = 0;
  int n, e;
  int sh[5] = '{0, 1, 2, 3, 5};

  timer_channel_mode_and_clock_select DUT (.clk_in(clk_in), .rst_in(rst_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .ext_count_clock_pin_in(ext_pin), .channel_a_pin_in(pa),
    .slow_onchip_divided_clock_in(sl), .fast_onchip_clock_in(fast),
    .count_en_out(count_en_out), .chan_capture_out(cap_out), .chan_ctrl_out(chan_ctrl_out),
    .chan_a_capture_trig_out(trig_a), .filter_cap_en_out(filt_out), .trig_cfg_out(trig_out),
    .timer_mode_out(md), .buffer_c_for_a_out(buf_c), .buffer_d_for_b_out(buf_d));
  ext_clock_model PARTNER (.clk_in(clk_in), .go_in(go), .pin_out(ext_pin));

  always #20 clk_in = ~clk_in;

  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up

  task cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  task wr(input logic [`TMR_ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr

  task rd(input logic [`TMR_ADDR_W-1:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    expq.push_back(exp);
    @(posedge clk_in);
    rd_in <= 1'b0;
  endtask : rd

  task settle;
    repeat (5) @(posedge clk_in);
    @(negedge clk_in);
  endtask : settle

  // fast tick every other cycle, read tracking, hang guard
  always @(posedge clk_in) begin
    fast <= ~fast;
    rd_prev <= rd_in;
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      wrap_up();
    end
  end

  // read data stand only in the cycle after the strobe
  always @(negedge clk_in) begin
    if (rd_prev)
      cmp("read data", expq.pop_front(), rdata_out);
  end

  initial begin
    void'($urandom(15));
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(`TMR_ADDR_AB_IO, `TMR_IO_RESET);
    rd(`TMR_ADDR_CD_IO, `TMR_IO_RESET);
    rd(10'h000, `TMR_READ_UNMAPPED);
    for (int m = 0; m < 4; m++) begin
      for (int i = 0; i < 8; i++) begin
        ab = 8'($urandom) & ~`TMR_AB_UNUSED_MASK;
        cd = 8'($urandom) & ~`TMR_CD_UNUSED_MASK;
        wf = 8'($urandom);
        mv = 8'(m) | (8'($urandom) & 8'h30);
        if (mv[4])
          cd[2] = ab[2];
        if (mv[5])
          cd[6] = ab[6];
        pa <= 1'($urandom);
        sl <= 1'($urandom);
        wr(`TMR_ADDR_MODE, mv);
        wr(`TMR_ADDR_AB_IO, ab);
        wr(`TMR_ADDR_CD_IO, cd);
        wr(`TMR_ADDR_FILTER, wf);
        wr(`TMR_ADDR_CTRL_TWO, 8'(i % 4));
        settle;
        cap = (m == 0) ? {cd[6], cd[2], ab[6], ab[2]} : 4'h0;
        cmp("capture", 8'(cap), 8'(cap_out));
        cmp("control", (m == 0) ? {cd[5:4], cd[1:0], ab[5:4], ab[1:0]} : 8'h00,
            chan_ctrl_out);
        cmp("chan a trig", 8'((m == 0 && ab[2]) ? (ab[3] ? pa : sl) : 1'b0),
            8'(trig_a));
        cmp("filter", 8'(wf[3:0] & cap), 8'(filt_out));
        cmp("trigger", 8'((m == 2 && i % 4 != 0) ? wf[5:4] : 2'b00), 8'(trig_out));
        cmp("mode", 8'(mv[1:0]), 8'(md));
        cmp("buffers", 8'(mv[5:4]), 8'({buf_d, buf_c}));
        rd(`TMR_ADDR_AB_IO, ab | `TMR_AB_UNUSED_MASK);
        rd(`TMR_ADDR_CD_IO, cd | `TMR_CD_UNUSED_MASK);
        rd(`TMR_ADDR_STATUS, {3'h0, m == 0, cap});
        rd(`TMR_ADDR_FILTER, wf & 8'h3F);
        rd(`TMR_ADDR_MODE, mv);
      end
    end
    for (int m = 0; m < 2; m++) begin
      wr(`TMR_ADDR_MODE, 8'(m));
      for (int s = 0; s < 8; s++) begin
        for (int g = 0; g < 2; g++) begin
          // oscillator and pin direction first, then the select
          wr(`TMR_ADDR_FAST_OSC, 8'(g));
          wr(`TMR_ADDR_PORT3_DIR, g ? 8'h00 : 8'h08);
          wr(`TMR_ADDR_CTRL_ONE, 8'(s));
          settle;
          @(posedge clk_in);
          go <= (s == 5);
          n = 0;
          // sample away from the launching edge
          repeat (96) begin
            @(negedge clk_in);
            if (count_en_out === 1'b1)
              n++;
          end
          @(posedge clk_in);
          go <= 1'b0;
          e = (s < 5) ? (96 >> sh[s]) : (s == 5) ? 5 * g : (s == 6) ? 48 * g : 0;
          cmp("count pulses", 8'(e), 8'(n));
        end
      end
    end
    repeat (4) @(posedge clk_in);
    wrap_up();
  end
endmodule : test_timer_channel_mode_and_clock_select
